// ### rtl/vlf_cfg.svh
// Purpose: Constants for the output limit and over-voltage fault block
// Assumes: 20 MHz clock, PMBus slave at a fixed 7-bit address
// Notes: Included by the top module and the host model
// Functional notes
// - Output target is clamped to the ceiling register value or the strap limit, whichever is lower.
// - A written ceiling never exceeds 115 percent of the strap voltage setting.
// - Margin high register value is the target during margin up.
// - Margin low register value is the target during margin down.
// - Target ramps at the linear slew rate in mode 000, else one LSB per ms, on margin or nominal changes.
// - Switching frequency register decodes from linear format in 1 kHz.
// - Phase_group_position upper nibble is group size, zero meaning sixteen.
// - Phase_group_position lower nibble is this rail's position in the group.
// - Output voltage is compared with the over-voltage threshold.
// - Every over-voltage fault pulls alert low and sets status.
// - Response code 10 disables output at once, then retries.
// - Restart attempts are limited by the three-bit retry field.
// - Retry count zero keeps output off until faults are cleared.
// - Retry count seven retries until disable or another fault.
// - Retry delay is retry time field plus one times 35 ms.
// - Retry delay spans 35 ms to 280 ms in 35 ms steps.
// - Voltage values use the mode exponent; mode 000 is linear.
// - Fault_flag_reset_cmd command resets status and the latched off state.
`ifndef VLF_CFG_SVH
`define VLF_CFG_SVH
`define VLF_CLK_HZ     20000000
`define VLF_MS_CYCLES  (`VLF_CLK_HZ / 1000)
`define VLF_RETRY_MS   35
`define VLF_CEIL_PCT   115
`define VLF_PCT        100
`define VLF_ADDR       7'h20
`define VLF_CMD_CLR    8'h03
`define VLF_CMD_CEIL   8'h24
`define VLF_CMD_MHI    8'h25
`define VLF_CMD_MLO    8'h26
`define VLF_CMD_RATE   8'h27
`define VLF_CMD_DROOP  8'h28
`define VLF_CMD_FSW    8'h33
`define VLF_CMD_ILV    8'h37
`define VLF_CMD_OVTH   8'h40
`define VLF_CMD_RSP    8'h41
`define VLF_CMD_STAT   8'h7a
`define VLF_RSP_ACT    7:6
`define VLF_RSP_CNT    5:3
`define VLF_RSP_TIME   2:0
`define VLF_ILV_NUM    7:4
`define VLF_ILV_POS    3:0
`define VLF_MODE_EXP   4:0
`define VLF_MODE_SEL   7:5
`define VLF_ACT_RETRY  2'h2
`define VLF_RTY_NONE   3'h0
`define VLF_RTY_INF    3'h7
`define VLF_MODE_LIN   3'h0
`define VLF_RST_CEIL   16'hffff
`define VLF_RST_OVTH   16'hffff
`define VLF_RST_RSP    8'h80
`define VLF_RST_WORD   16'h0000
`endif

// ### rtl/vlf_pkg.sv
// Purpose: Types shared by the limit and fault block
// Assumes: Nothing beyond the constants header
// Notes: States and the 16-bit data word
package vlf_pkg;
  typedef logic [15:0] vlf_word_t;
  typedef enum logic [2:0] {
    B_IDLE, B_ADDR, B_CMD, B_WR, B_ACK, B_RD, B_MACK
  } vlf_bus_t;
  typedef enum logic [1:0] {P_OFF, P_RUN, P_WAIT, P_LATCH} vlf_pwr_t;
endpackage

// ### rtl/vlf_tmr_if.sv
// Purpose: Millisecond tick and retry delay signals
// Assumes: One clock for all users
// Notes: Top drives start and length
`timescale 1ns/1ns
interface vlf_tmr_if;
  logic       tick;
  logic       start;
  logic [8:0] len_ms;
  logic       done;
  modport tk (input start, output tick);
  modport tm (input tick, start, len_ms, output done);
endinterface

// ### rtl/vlf_tick.sv
// Purpose: Millisecond enable pulse from the system clock
// Assumes: DIV cycles per millisecond
// Notes: Restarted by a delay start for exact spacing
`timescale 1ns/1ns
module vlf_tick #(
  parameter int unsigned DIV = 20000
) (
  input wire logic clk_i,
  input wire logic srst_i,
  vlf_tmr_if.tk    tk
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (srst_i || tk.start) begin
      cnt_r   <= '0;
      tk.tick <= 1'b0;
    end else if (cnt_r == CW'(DIV - 1)) begin
      cnt_r   <= '0;
      tk.tick <= 1'b1;
    end else begin
      cnt_r   <= cnt_r + 1'b1;
      tk.tick <= 1'b0;
    end
  end
endmodule

// ### rtl/vlf_delay.sv
// Purpose: Retry delay counted in millisecond ticks
// Assumes: Length loaded with start, at least one
// Notes: Done is a one-cycle pulse
`timescale 1ns/1ns
module vlf_delay (
  input wire logic clk_i,
  input wire logic srst_i,
  vlf_tmr_if.tm    tm
);
  logic [8:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r   <= 9'h000;
      tm.done <= 1'b0;
    end else if (tm.start) begin
      cnt_r   <= tm.len_ms;
      tm.done <= 1'b0;
    end else begin
      tm.done <= tm.tick && (cnt_r == 9'h001);
      if (tm.tick && (cnt_r != 9'h000))
        cnt_r <= cnt_r - 9'h001;
    end
  end

  retry_done_a: assert property (@(posedge clk_i) disable iff (srst_i)
    tm.done |-> $past(cnt_r) == 9'h001 && $past(tm.tick))
    else $error("retry delay ended early");
endmodule

// ### rtl/vlf_top.sv
// Purpose: Output limit, margin, slew and over-voltage fault response
// Assumes: Measured and commanded voltages share the mode format
// Notes: Registers reached over PMBus pins only
`timescale 1ns/1ns
`include "vlf_cfg.svh"
module vlf_top #(
  parameter int unsigned MS_CYC = `VLF_MS_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  output logic                   alert_line_n_o,
  input  wire vlf_pkg::vlf_word_t vout_cmd_i,
  input  wire vlf_pkg::vlf_word_t vout_meas_i,
  input  wire vlf_pkg::vlf_word_t voltage_strap_pin_i,
  input  wire logic [7:0]        vout_mode_i,
  input  wire logic              margin_hi_i,
  input  wire logic              margin_lo_i,
  input  wire logic              output_en_i,
  input  wire logic              other_fault_i,
  output vlf_pkg::vlf_word_t     vout_target_o,
  output vlf_pkg::vlf_word_t     load_line_o,
  output vlf_pkg::vlf_word_t     fsw_khz_o,
  output logic [4:0]             group_size_o,
  output logic [3:0]             phase_pos_o,
  output logic                   out_on_o,
  output logic                   ov_fault_o
);
  import vlf_pkg::*;

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic       scl_d_r;
  logic       sda_d_r;
  vlf_word_t  strap_s1_r;
  vlf_word_t  strap_s2_r;
  vlf_word_t  strap_r;
  vlf_word_t  strap_lim_r;
  logic [23:0] lim_w;
  vlf_bus_t   st_r;
  vlf_bus_t   nxt_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [7:0] cmd_r;
  vlf_word_t  wb_r;
  logic [1:0] nw_r;
  logic [1:0] nr_r;
  logic       rw_r;
  logic       cmd_ok_r;
  logic       sda_oe_r;
  logic       wr_go_r;
  logic       clr_go_r;
  vlf_word_t  ceil_r;
  vlf_word_t  mhi_r;
  vlf_word_t  mlo_r;
  vlf_word_t  rate_r;
  vlf_word_t  droop_r;
  vlf_word_t  fsw_r;
  vlf_word_t  ilv_r;
  vlf_word_t  ovth_r;
  logic [7:0] rsp_r;
  vlf_word_t  rd_w;
  logic [7:0] tx_w;
  vlf_word_t  ceil_eff_w;
  vlf_word_t  raw_w;
  vlf_word_t  goal_w;
  vlf_word_t  step_w;
  vlf_word_t  target_r;
  logic signed [6:0] adj_w;
  vlf_pwr_t   pwr_r;
  logic [2:0] cnt_r;
  logic       out_on_r;
  logic       ov_stat_r;
  logic       alert_n_r;
  logic       ov_now_w;
  logic       scl_w;
  logic       sda_w;
  logic       scl_rise_w;
  logic       scl_fall_w;
  logic       start_w;
  logic       stop_w;
  logic       start_r;
  logic [8:0] len_r;
  vlf_tmr_if  tif ();

  function automatic vlf_word_t lin_dec(input vlf_word_t v,
                                        input logic signed [6:0] adj);
    logic signed [6:0] e;
    logic [31:0]       m;
    e = $signed({{2{v[15]}}, v[15:11]}) + adj;
    m = {21'h00_0000, v[10:0]};
    lin_dec = 16'h0000;
    if (v[10])
      lin_dec = 16'h0000;
    else if (e > 7'sh0f)
      lin_dec = 16'hffff;
    else if (e >= 7'sh00) begin
      m = m << e[3:0];
      lin_dec = (|m[31:16]) ? 16'hffff : m[15:0];
    end else if (e > -7'sh10) begin
      m = m >> 4'(-e);
      lin_dec = m[15:0];
    end
  endfunction

  function automatic logic cmd_known(input logic [7:0] c);
    case (c)
      `VLF_CMD_CLR, `VLF_CMD_CEIL, `VLF_CMD_MHI, `VLF_CMD_MLO,
      `VLF_CMD_RATE, `VLF_CMD_DROOP, `VLF_CMD_FSW, `VLF_CMD_ILV,
      `VLF_CMD_OVTH, `VLF_CMD_RSP, `VLF_CMD_STAT: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  assign scl_w      = scl_s_r[1];
  assign sda_w      = sda_s_r[1];
  assign scl_rise_w = scl_w & ~scl_d_r;
  assign scl_fall_w = ~scl_w & scl_d_r;
  assign start_w    = scl_w & scl_d_r & sda_d_r & ~sda_w;
  assign stop_w     = scl_w & scl_d_r & ~sda_d_r & sda_w;

  // Strap caught while reset is held
  always_ff @(posedge clk_i) begin
    strap_s1_r <= voltage_strap_pin_i;
    strap_s2_r <= strap_s1_r;
    if (srst_i)
      strap_r <= strap_s2_r;
  end

  assign lim_w = (24'(strap_r) * 24'(`VLF_CEIL_PCT)) / 24'(`VLF_PCT);

  always_ff @(posedge clk_i) begin
    strap_lim_r <= (|lim_w[23:16]) ? 16'hffff : lim_w[15:0];
  end

  // Read data
  always_comb begin
    case (cmd_r)
      `VLF_CMD_CEIL:  rd_w = ceil_r;
      `VLF_CMD_MHI:   rd_w = mhi_r;
      `VLF_CMD_MLO:   rd_w = mlo_r;
      `VLF_CMD_RATE:  rd_w = rate_r;
      `VLF_CMD_DROOP: rd_w = droop_r;
      `VLF_CMD_FSW:   rd_w = fsw_r;
      `VLF_CMD_ILV:   rd_w = ilv_r;
      `VLF_CMD_OVTH:  rd_w = ovth_r;
      `VLF_CMD_RSP:   rd_w = {8'h00, rsp_r};
      `VLF_CMD_STAT:  rd_w = {8'h00, ov_stat_r, 7'h00};
      default:        rd_w = 16'h0000;
    endcase
  end

  assign tx_w = nr_r[0] ? rd_w[15:8] : rd_w[7:0];

  // PMBus slave
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r     <= B_IDLE;
      nxt_r    <= B_IDLE;
      sh_r     <= 8'h00;
      bit_r    <= 4'h0;
      cmd_r    <= 8'h00;
      wb_r     <= 16'h0000;
      nw_r     <= 2'h0;
      nr_r     <= 2'h0;
      rw_r     <= 1'b0;
      cmd_ok_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_go_r  <= 1'b0;
      clr_go_r <= 1'b0;
    end else begin
      wr_go_r  <= 1'b0;
      clr_go_r <= 1'b0;
      if (stop_w) begin
        st_r     <= B_IDLE;
        sda_oe_r <= 1'b0;
        cmd_ok_r <= 1'b0;
        if (cmd_ok_r && !rw_r) begin
          if (cmd_r == `VLF_CMD_CLR)
            clr_go_r <= (nw_r == 2'h0);
          else if (cmd_r == `VLF_CMD_RSP || cmd_r == `VLF_CMD_STAT)
            wr_go_r <= (nw_r == 2'h1);
          else
            wr_go_r <= (nw_r == 2'h2);
        end
      end else if (start_w) begin
        st_r     <= B_ADDR;
        bit_r    <= 4'h0;
        sda_oe_r <= 1'b0;
        nw_r     <= 2'h0;
        nr_r     <= 2'h0;
      end else if (scl_rise_w) begin
        case (st_r)
          B_ADDR, B_CMD, B_WR: begin
            if (bit_r < 4'h8) begin
              sh_r  <= {sh_r[6:0], sda_w};
              bit_r <= bit_r + 4'h1;
            end
          end
          B_MACK: begin
            st_r  <= sda_w ? B_IDLE : B_ACK;
            nxt_r <= B_RD;
          end
          default: ;
        endcase
      end else if (scl_fall_w) begin
        case (st_r)
          B_ADDR: begin
            if (bit_r == 4'h8) begin
              if (sh_r[7:1] == `VLF_ADDR && (!sh_r[0] || cmd_ok_r)) begin
                sda_oe_r <= 1'b1;
                rw_r     <= sh_r[0];
                nxt_r    <= sh_r[0] ? B_RD : B_CMD;
                st_r     <= B_ACK;
                if (!sh_r[0])
                  cmd_ok_r <= 1'b0;
              end else
                st_r <= B_IDLE;
            end
          end
          B_CMD: begin
            if (bit_r == 4'h8) begin
              if (cmd_known(sh_r)) begin
                cmd_r    <= sh_r;
                cmd_ok_r <= 1'b1;
                sda_oe_r <= 1'b1;
                nxt_r    <= B_WR;
                st_r     <= B_ACK;
              end else
                st_r <= B_IDLE;
            end
          end
          B_WR: begin
            if (bit_r == 4'h8) begin
              wb_r     <= {sh_r, wb_r[15:8]};
              nw_r     <= (nw_r == 2'h3) ? nw_r : nw_r + 2'h1;
              sda_oe_r <= 1'b1;
              nxt_r    <= B_WR;
              st_r     <= B_ACK;
            end
          end
          B_ACK: begin
            st_r     <= nxt_r;
            bit_r    <= 4'h0;
            sda_oe_r <= 1'b0;
            if (nxt_r == B_RD) begin
              sh_r     <= tx_w;
              sda_oe_r <= ~tx_w[7];
              bit_r    <= 4'h1;
            end
          end
          B_RD: begin
            if (bit_r == 4'h8) begin
              sda_oe_r <= 1'b0;
              nr_r     <= nr_r + 2'h1;
              st_r     <= B_MACK;
            end else begin
              sda_oe_r <= ~sh_r[6];
              sh_r     <= {sh_r[6:0], 1'b0};
              bit_r    <= bit_r + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_r;

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ceil_r  <= `VLF_RST_CEIL;
      mhi_r   <= `VLF_RST_WORD;
      mlo_r   <= `VLF_RST_WORD;
      rate_r  <= `VLF_RST_WORD;
      droop_r <= `VLF_RST_WORD;
      fsw_r   <= `VLF_RST_WORD;
      ilv_r   <= `VLF_RST_WORD;
      ovth_r  <= `VLF_RST_OVTH;
      rsp_r   <= `VLF_RST_RSP;
    end else if (wr_go_r) begin
      case (cmd_r)
        `VLF_CMD_CEIL:  ceil_r <= (wb_r > strap_lim_r) ? strap_lim_r : wb_r;
        `VLF_CMD_MHI:   mhi_r   <= wb_r;
        `VLF_CMD_MLO:   mlo_r   <= wb_r;
        `VLF_CMD_RATE:  rate_r  <= wb_r;
        `VLF_CMD_DROOP: droop_r <= wb_r;
        `VLF_CMD_FSW:   fsw_r   <= wb_r;
        `VLF_CMD_ILV:   ilv_r   <= wb_r;
        `VLF_CMD_OVTH:  ovth_r  <= wb_r;
        `VLF_CMD_RSP:   rsp_r   <= wb_r[15:8];
        default: ;
      endcase
    end
  end

  // Target selection and clamp
  assign ceil_eff_w = (ceil_r < strap_lim_r) ? ceil_r : strap_lim_r;
  assign raw_w = margin_hi_i ? mhi_r : (margin_lo_i ? mlo_r : vout_cmd_i);
  assign goal_w = (raw_w > ceil_eff_w) ? ceil_eff_w : raw_w;
  assign adj_w = -$signed({{2{vout_mode_i[4]}}, vout_mode_i[`VLF_MODE_EXP]});

  always_comb begin
    step_w = 16'h0001;
    if (vout_mode_i[`VLF_MODE_SEL] == `VLF_MODE_LIN)
      step_w = lin_dec(rate_r, adj_w);
    if (step_w == 16'h0000)
      step_w = 16'h0001;
  end

  // Slew toward the goal once per millisecond
  always_ff @(posedge clk_i) begin
    if (srst_i)
      target_r <= 16'h0000;
    else if (tif.tick) begin
      if (goal_w > target_r)
        target_r <= (goal_w - target_r > step_w) ? target_r + step_w : goal_w;
      else if (goal_w < target_r)
        target_r <= (target_r - goal_w > step_w) ? target_r - step_w : goal_w;
    end
  end

  // Decoded configuration outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fsw_khz_o    <= 16'h0000;
      group_size_o <= 5'h10;
      phase_pos_o  <= 4'h0;
      load_line_o  <= 16'h0000;
    end else begin
      fsw_khz_o    <= lin_dec(fsw_r, 7'sh00);
      group_size_o <= {ilv_r[`VLF_ILV_NUM] == 4'h0, ilv_r[`VLF_ILV_NUM]};
      phase_pos_o  <= ilv_r[`VLF_ILV_POS];
      load_line_o  <= droop_r;
    end
  end

  assign ov_now_w = out_on_r && (vout_meas_i > ovth_r);

  // Fault response
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwr_r    <= P_OFF;
      out_on_r <= 1'b0;
      cnt_r    <= 3'h0;
      start_r  <= 1'b0;
      len_r    <= 9'h000;
    end else begin
      start_r <= 1'b0;
      if (pwr_r != P_LATCH && (!output_en_i || other_fault_i)) begin
        pwr_r    <= P_OFF;
        out_on_r <= 1'b0;
        cnt_r    <= 3'h0;
      end else begin
        case (pwr_r)
          P_OFF: begin
            pwr_r    <= P_RUN;
            out_on_r <= 1'b1;
            if (clr_go_r)
              cnt_r <= 3'h0;
          end
          P_RUN: begin
            if (ov_now_w && rsp_r[`VLF_RSP_ACT] == `VLF_ACT_RETRY) begin
              out_on_r <= 1'b0;
              if (rsp_r[`VLF_RSP_CNT] == `VLF_RTY_NONE)
                pwr_r <= P_LATCH;
              else if (rsp_r[`VLF_RSP_CNT] != `VLF_RTY_INF &&
                       cnt_r == rsp_r[`VLF_RSP_CNT])
                pwr_r <= P_LATCH;
              else begin
                pwr_r   <= P_WAIT;
                start_r <= 1'b1;
                len_r   <= 9'((9'(rsp_r[`VLF_RSP_TIME]) + 9'h001) *
                              9'(`VLF_RETRY_MS));
              end
            end else if (clr_go_r)
              cnt_r <= 3'h0;
          end
          P_WAIT: begin
            if (tif.done) begin
              pwr_r    <= P_RUN;
              out_on_r <= 1'b1;
              if (rsp_r[`VLF_RSP_CNT] != `VLF_RTY_INF)
                cnt_r <= cnt_r + 3'h1;
            end
          end
          P_LATCH: begin
            if (clr_go_r) begin
              pwr_r <= P_OFF;
              cnt_r <= 3'h0;
            end
          end
          default: pwr_r <= P_OFF;
        endcase
      end
    end
  end

  // Sticky fault status and alert, set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ov_stat_r <= 1'b0;
      alert_n_r <= 1'b1;
    end else begin
      ov_stat_r <= ov_now_w | (ov_stat_r & ~clr_go_r);
      alert_n_r <= ~(ov_now_w | (ov_stat_r & ~clr_go_r));
    end
  end

  assign tif.start      = start_r;
  assign tif.len_ms     = len_r;
  assign vout_target_o  = target_r;
  assign out_on_o       = out_on_r;
  assign ov_fault_o     = ov_stat_r;
  assign alert_line_n_o = alert_n_r;

  vlf_tick #(.DIV(MS_CYC)) u_tick (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tk     (tif)
  );

  vlf_delay u_delay (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tm     (tif)
  );

  ceil_clamp_a: assert property (
    raw_w > ceil_eff_w |-> goal_w == ceil_eff_w)
    else $error("goal not clamped to ceiling");
  ceil_bound_a: assert property (
    wr_go_r && cmd_r == `VLF_CMD_CEIL |=> ceil_r <= strap_lim_r)
    else $error("ceiling above strap limit");
  margin_high_a: assert property (
    margin_hi_i && mhi_r <= ceil_eff_w |-> goal_w == mhi_r)
    else $error("margin high target not used");
  margin_low_a: assert property (
    !margin_hi_i && margin_lo_i && mlo_r <= ceil_eff_w |-> goal_w == mlo_r)
    else $error("margin low target not used");
  slew_tick_a: assert property (
    !$stable(target_r) |-> $past(tif.tick))
    else $error("target moved without a tick");
  group_zero_a: assert property (
    ilv_r[7:4] == 4'h0 ##1 $stable(ilv_r) |-> group_size_o == 5'h10)
    else $error("group size zero not sixteen");
  ov_alert_a: assert property (
    ov_now_w |=> !alert_line_n_o && ov_fault_o)
    else $error("fault did not raise alert");
  ov_disable_a: assert property (
    ov_now_w && rsp_r[7:6] == 2'h2 && output_en_i && !other_fault_i
    |=> !out_on_o)
    else $error("output not disabled on fault");
  latch_hold_a: assert property (
    pwr_r == P_LATCH && !clr_go_r |=> pwr_r == P_LATCH && !out_on_o)
    else $error("latched off state left early");
  retry_len_a: assert property (
    start_r |-> len_r == 9'((9'(rsp_r[2:0]) + 9'h001) * 9'h023))
    else $error("retry delay length wrong");
  retry_cap_a: assert property (
    pwr_r == P_WAIT |-> rsp_r[5:3] == 3'h7 || cnt_r < rsp_r[5:3])
    else $error("retry beyond count limit");
  clear_fault_a: assert property (
    clr_go_r && !ov_now_w |=> !ov_fault_o && alert_line_n_o)
    else $error("fault_flag_reset_cmd left status set");
endmodule

// ### testbench/vlf_host_model.sv
// Purpose: PMBus host for the limit and fault block
// Assumes: Open-drain data line with pull-up
// Notes: Q clocks per quarter bit
`timescale 1ns/1ns
`include "vlf_cfg.svh"
module vlf_host_model #(
  parameter int Q = 6
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic qw();
    repeat (Q) @(posedge clk_i);
  endtask
  task automatic frame(input logic a, input logic b);
    sda_o <= a;
    qw();
    scl_o <= 1'b1;
    qw();
    sda_o <= b;
    qw();
  endtask
  task automatic start();
    frame(1'b1, 1'b0);
    scl_o <= 1'b0;
    qw();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    qw();
    scl_o <= 1'b1;
    qw();
    r = sda_i;
    qw();
    scl_o <= 1'b0;
    qw();
  endtask
  task automatic byte_io(input logic [7:0] b, input logic m,
                         output logic [7:0] r, output logic a);
    logic t;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], t);
      r[i] = t;
    end
    bit_io(m, a);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
                    input int n, output logic ok);
    logic [7:0] r;
    logic       a;
    logic       k;
    start();
    byte_io({`VLF_ADDR, 1'b0}, 1'b1, r, k);
    byte_io(c, 1'b1, r, a);
    k = k | a;
    for (int i = 0; i < n; i++) begin
      byte_io(d[8*i +: 8], 1'b1, r, a);
      k = k | a;
    end
    frame(1'b0, 1'b1);
    ok = ~k;
  endtask
  task automatic rd(input logic [7:0] c, input int n,
                    output logic [15:0] d);
    logic [7:0] r;
    logic       a;
    d = '0;
    start();
    byte_io({`VLF_ADDR, 1'b0}, 1'b1, r, a);
    byte_io(c, 1'b1, r, a);
    start();
    byte_io({`VLF_ADDR, 1'b1}, 1'b1, r, a);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, i == n - 1, r, a);
      d[8*i +: 8] = r;
    end
    frame(1'b0, 1'b1);
  endtask
endmodule

// ### testbench/vout_limit_and_ov_fault_cfg_tb_top.sv
// Purpose: Self-checking bench for the limit and fault block
// Assumes: 20 clocks per millisecond tick
// Notes: Registers reached only through the host model
`timescale 1ns/1ns
module vout_limit_and_ov_fault_cfg_tb_top;
  import vlf_pkg::*;
  localparam int MS = 20;
  localparam logic [7:0] CM [7] = '{8'h25, 8'h26, 8'h27, 8'h28,
                                    8'h33, 8'h37, 8'h40};
  localparam vlf_word_t VL [7] = '{16'h0300, 16'h0200, 16'h0100,
                                   16'h0005, 16'h0190, 16'h0035, 16'h0500};
  logic       clk_i    = 1'b0;
  logic       srst_i   = 1'b1;
  logic       mhi      = 1'b0;
  logic       mlo      = 1'b0;
  logic       en       = 1'b1;
  logic [7:0] mode     = 8'h00;
  logic       scl, sda_h, sda_oe, alert_n, on, ovf;
  logic [4:0] grp;
  logic [3:0] pos;
  vlf_word_t  cmd      = '0;
  vlf_word_t  meas     = '0;
  vlf_word_t  tgt, ll, fsw;
  int         failures = 0;
  int         checks   = 0;
  wire        sda_w    = sda_h & ~sda_oe;
  vlf_top #(.MS_CYC(MS)) u_vlf_top (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(), .sda_oe_o(sda_oe), .alert_line_n_o(alert_n),
    .vout_cmd_i(cmd), .vout_meas_i(meas), .voltage_strap_pin_i(16'h0400),
    .vout_mode_i(mode), .margin_hi_i(mhi), .margin_lo_i(mlo),
    .output_en_i(en), .other_fault_i(1'b0), .vout_target_o(tgt),
    .load_line_o(ll), .fsw_khz_o(fsw), .group_size_o(grp),
    .phase_pos_o(pos), .out_on_o(on), .ov_fault_o(ovf));
  vlf_host_model u_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_o(sda_h));
  always #25 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_on(input logic v, output int n);
    n = 0;
    while (on !== v && n < 6000) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic retries(input int k, input int len);
    int n;
    for (int i = 0; i < k; i++) begin
      wait_on(1'b0, n);
      wait_on(1'b1, n);
      chk({15'h0000, n >= len - 1 && n <= len + 4}, 16'h0001);
    end
  endtask
  task automatic clr();
    logic ok;
    @(posedge clk_i);
    meas <= '0;
    en <= 1'b1;
    u_host.wr(8'h03, 16'h0000, 0, ok);
    repeat (8) @(negedge clk_i);
    chk({14'h0000, ovf, on}, 16'h0001);
  endtask
  task automatic aim(input logic h, input logic l, input vlf_word_t e);
    @(posedge clk_i);
    mhi <= h;
    mlo <= l;
    repeat (200) @(negedge clk_i);
    chk(tgt, e);
  endtask
  task automatic ov_set(input vlf_word_t v);
    @(posedge clk_i);
    meas <= v;
  endtask
  initial begin
    vlf_word_t d;
    logic      ok;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    u_host.rd(8'h24, 2, d);
    chk(d, 16'hffff);
    u_host.rd(8'h41, 1, d);
    chk(d, 16'h0080);
    chk({11'h000, grp}, 16'h0010);
    u_host.wr(8'h24, 16'h0600, 2, ok);
    u_host.rd(8'h24, 2, d);
    chk(d, 16'h0499);
    u_host.wr(8'h55, 16'h1234, 2, ok);
    chk({15'h0000, ok}, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      u_host.wr(CM[i], VL[i], 2, ok);
      u_host.rd(CM[i], 2, d);
      chk(d, VL[i]);
    end
    chk(ll, 16'h0005);
    chk(fsw, 16'h0190);
    chk({7'h00, grp, pos}, 16'h0035);
    @(posedge clk_i);
    cmd <= 16'h0800;
    for (int i = 0; i < 99 && tgt === 16'h0000; i++) @(negedge clk_i);
    chk(tgt, 16'h0100);
    aim(1'b0, 1'b0, 16'h0499);
    aim(1'b1, 1'b0, 16'h0300);
    aim(1'b0, 1'b1, 16'h0200);
    ov_set(16'h0500);
    repeat (3) @(negedge clk_i);
    chk({15'h0000, ovf}, 16'h0000);
    ov_set(16'h0501);
    @(posedge clk_i);
    @(negedge clk_i);
    chk({13'h0000, ovf, alert_n, on}, 16'h0004);
    repeat (1500) @(negedge clk_i);
    chk({15'h0000, on}, 16'h0000);
    u_host.rd(8'h7a, 1, d);
    chk(d & 16'h0080, 16'h0080);
    clr();
    u_host.wr(8'h41, 16'h0097, 1, ok);
    u_host.rd(8'h41, 1, d);
    chk(d, 16'h0097);
    ov_set(16'h0600);
    retries(2, 8 * 35 * MS);
    repeat (6000) @(negedge clk_i);
    chk({15'h0000, on}, 16'h0000);
    clr();
    u_host.wr(8'h41, 16'h00b8, 1, ok);
    ov_set(16'h0600);
    retries(3, 35 * MS);
    @(posedge clk_i);
    en <= 1'b0;
    repeat (1500) @(negedge clk_i);
    chk({15'h0000, on}, 16'h0000);
    clr();
    u_host.wr(8'h41, 16'h0000, 1, ok);
    ov_set(16'h0600);
    repeat (3) @(negedge clk_i);
    chk({14'h0000, on, alert_n}, 16'h0002);
    @(posedge clk_i);
    mode <= 8'h1f;
    mlo  <= 1'b0;
    for (int i = 0; i < 99 && tgt === 16'h0200; i++) @(negedge clk_i);
    chk(tgt, 16'h0400);
    end_of_test();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    end_of_test();
  end
endmodule
